// file: phase_noload_and_compute_config_tb.sv
`timescale 1ns/1ps
module phase_noload_and_compute_config_tb
    import pnc_pkg::*;
;
    logic aclk;
    logic aresetn;
    logic [ADDR_W-1:0] awaddr;
    logic awvalid;
    logic awready;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready;
    logic [ADDR_W-1:0] araddr;
    logic arvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready;
    pnc_noload_t noload_detect;
    pnc_noload_t noload_flags;
    pnc_compute_t compute_mode;
    logic irq;
    int n_errors = 0;
    int n_tests = 0;
    logic [31:0] seed = 32'h0000_c8c6;
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    logic [33:0] r_exp;

    pnc_noload_compute i_dut (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .noload_detect(noload_detect), .noload_flags(noload_flags),
        .compute_mode(compute_mode), .irq(irq)
    );

    // Free-running 100 MHz clock
    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    function automatic logic [31:0] xorshift(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask

    // Address and data offered together, each released once taken; only the watchdog ends a hang
    task automatic wr(input logic [15:0] idx, input logic [31:0] d, input logic [1:0] er);
        bq.push_back(er);
        awaddr <= {idx, 2'b00};
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= 4'hf;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        // Idle edge so the next call never re-drives a strobe in this step
        @(posedge aclk);
    endtask

    task automatic rd(input logic [15:0] idx, input logic [31:0] d, input logic [1:0] er);
        rq.push_back({er, d});
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready)
                arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        // Idle edge so the next call never re-drives rready in this step
        @(posedge aclk);
    endtask

    // Response monitor: each accepted answer is matched against the oldest expectation
    always @(posedge aclk)
    begin
        if (rvalid && rready)
        begin
            r_exp = (rq.size() > 0) ? rq.pop_front() : 34'h3_ffff_ffff;
            chk({30'h0000_0000, rresp}, {30'h0000_0000, r_exp[33:32]});
            chk(rdata, r_exp[31:0]);
        end
        if (bvalid && bready)
            chk({30'h0000_0000, bresp}, {30'h0000_0000, (bq.size() > 0) ? bq.pop_front() : 2'h3});
    end

    // Watchdog sized well above the few hundred cycles the sequence needs
    initial
    begin
        cyc(20000);
        n_errors++;
        print_verdict();
    end

    initial
    begin
        logic [15:0] d;
        logic [8:0] r;
        logic [2:0] ev;
        aresetn = 1'b0;
        awaddr = '0;
        awvalid = 1'b0;
        wdata = 32'h0000_0000;
        wstrb = 4'h0;
        wvalid = 1'b0;
        bready = 1'b0;
        araddr = '0;
        arvalid = 1'b0;
        rready = 1'b0;
        noload_detect = '0;
        cyc(12);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk({16'h0000, compute_mode}, {16'h0000, COMPUTE_RESET});
        chk({23'h00_0000, noload_flags}, 32'h0000_0000);
        chk({31'h0000_0000, irq}, 32'h0000_0000);
        rd(IDX_COMPUTE, {16'h0000, COMPUTE_RESET}, RESP_OKAY);
        rd(IDX_NOLOAD, 32'h0000_0000, RESP_OKAY);
        rd(IDX_IRQ_STATUS, 32'h0000_0000, RESP_OKAY);
        rd(IDX_IRQ_MASK, 32'h0000_0000, RESP_OKAY);
        // Every angle code, with random phase selections and upper lanes that must be dropped
        for (int a = 0; a < 4; a++)
        begin
            seed = xorshift(seed);
            d = {seed[15:11], a[1:0], seed[8:0]};
            wr(IDX_COMPUTE, {seed[31:16], d}, RESP_OKAY);
            chk({16'h0000, compute_mode}, {16'h0000, d});
            rd(IDX_COMPUTE, {16'h0000, d}, RESP_OKAY);
        end
        // software sets the line-frequency bit for a 60 Hz network
        d = 16'h41ff;
        wr(IDX_COMPUTE, {16'h0000, d}, RESP_OKAY);
        chk({31'h0000_0000, compute_mode.line_freq_select}, 32'h0000_0001);
        rd(IDX_COMPUTE, {16'h0000, d}, RESP_OKAY);
        // Random detector patterns: flags follow, each group raises its own event bit
        for (int i = 0; i < 8; i++)
        begin
            noload_detect <= '0;
            cyc(2);
            wr(IDX_IRQ_STATUS, 32'h0000_0007, RESP_OKAY);
            seed = xorshift(seed);
            r = seed[8:0];
            ev[EV_TOTAL] = |r[2:0];
            ev[EV_FUND] = |r[5:3];
            ev[EV_APP] = |r[8:6];
            noload_detect <= r;
            cyc(2);
            chk({23'h00_0000, noload_flags}, {23'h00_0000, r});
            rd(IDX_NOLOAD, {23'h00_0000, r}, RESP_OKAY);
            rd(IDX_IRQ_STATUS, {29'h0000_0000, ev}, RESP_OKAY);
        end
        // Masking and write-one-clear while the detector stays asserted
        noload_detect <= '0;
        cyc(2);
        wr(IDX_IRQ_STATUS, 32'h0000_0007, RESP_OKAY);
        wr(IDX_IRQ_MASK, 32'h0000_0002, RESP_OKAY);
        noload_detect <= 9'h1ff;
        cyc(3);
        chk({31'h0000_0000, irq}, 32'h0000_0001);
        rd(IDX_IRQ_STATUS, 32'h0000_0007, RESP_OKAY);
        wr(IDX_IRQ_MASK, 32'h0000_0000, RESP_OKAY);
        cyc(2);
        chk({31'h0000_0000, irq}, 32'h0000_0000);
        wr(IDX_IRQ_MASK, 32'h0000_0007, RESP_OKAY);
        wr(IDX_IRQ_STATUS, 32'h0000_0002, RESP_OKAY);
        cyc(2);
        chk({31'h0000_0000, irq}, 32'h0000_0001);
        rd(IDX_IRQ_STATUS, 32'h0000_0005, RESP_OKAY);
        wr(IDX_IRQ_STATUS, 32'h0000_0005, RESP_OKAY);
        cyc(2);
        chk({31'h0000_0000, irq}, 32'h0000_0000);
        rd(IDX_IRQ_STATUS, 32'h0000_0000, RESP_OKAY);
        // Leaving no-load clears the flags; the status register ignores writes
        noload_detect <= '0;
        cyc(2);
        chk({23'h00_0000, noload_flags}, 32'h0000_0000);
        wr(IDX_NOLOAD, 32'h0000_ffff, RESP_OKAY);
        rd(IDX_NOLOAD, 32'h0000_0000, RESP_OKAY);
        // Unmapped address is refused on both paths
        wr(16'h0000, 32'h0000_1234, RESP_SLVERR);
        rd(16'h0000, 32'h0000_0000, RESP_SLVERR);
        rd(IDX_COMPUTE, {16'h0000, d}, RESP_OKAY);
        cyc(4);
        print_verdict();
    end
endmodule

// file: pnc_noload_compute.sv
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module pnc_noload_compute
    import pnc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire pnc_noload_t noload_detect,
    output pnc_noload_t noload_flags,
    output pnc_compute_t compute_mode,
    output logic irq
);

    // Word decode shared by the read and write paths
    function automatic pnc_reg_t decode(input logic [ADDR_W-1:0] a);
        pnc_reg_t id;
        id = PNC_REG_NONE;
        if (a[1:0] == 2'b00)
        begin
            case (a[ADDR_W-1:2])
                IDX_NOLOAD: id = PNC_REG_NOLOAD;
                IDX_COMPUTE: id = PNC_REG_COMPUTE;
                IDX_IRQ_STATUS: id = PNC_REG_IRQ_ST;
                IDX_IRQ_MASK: id = PNC_REG_IRQ_MASK;
                default: id = PNC_REG_NONE;
            endcase
        end
        return id;
    endfunction

    // Byte-lane merge for the two low lanes of a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw, input logic [1:0] strb);
        logic [15:0] r;
        r = old;
        if (strb[0])
        begin
            r[7:0] = nw[7:0];
        end
        if (strb[1])
        begin
            r[15:8] = nw[15:8];
        end
        return r;
    endfunction

    logic aw_held_r, aw_held_nxt;
    logic w_held_r, w_held_nxt;
    logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
    logic [31:0] wdata_r, wdata_nxt;
    logic [3:0] wstrb_r, wstrb_nxt;
    logic awready_r, awready_nxt;
    logic wready_r, wready_nxt;
    logic bvalid_r, bvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt;
    logic arready_r, arready_nxt;
    logic rvalid_r, rvalid_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [1:0] rresp_r, rresp_nxt;
    logic wr_fire;
    pnc_reg_t wr_id;
    pnc_reg_t rd_id;

    pnc_noload_t status_r, status_nxt;
    logic [15:0] cfg_r, cfg_nxt;
    logic [2:0] irq_st_r, irq_st_nxt;
    logic [2:0] mask_r, mask_nxt;
    logic irq_r, irq_nxt;
    logic [2:0] ev_set;

    // Bus handshakes: address and data are caught in either order,
    // the write commits once both are held and no response is pending
    always_comb
    begin
        aw_held_nxt = aw_held_r;
        w_held_nxt = w_held_r;
        awaddr_nxt = awaddr_r;
        wdata_nxt = wdata_r;
        wstrb_nxt = wstrb_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        arready_nxt = arready_r;
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        wr_id = decode(awaddr_r);
        rd_id = decode(araddr);
        wr_fire = aw_held_r && w_held_r && !bvalid_r;
        if (awvalid && awready_r)
        begin
            aw_held_nxt = 1'b1;
            awaddr_nxt = awaddr;
        end
        if (wvalid && wready_r)
        begin
            w_held_nxt = 1'b1;
            wdata_nxt = wdata;
            wstrb_nxt = wstrb;
        end
        if (bvalid_r && bready)
        begin
            bvalid_nxt = 1'b0;
        end
        if (wr_fire)
        begin
            aw_held_nxt = 1'b0;
            w_held_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = (wr_id == PNC_REG_NONE) ? RESP_SLVERR : RESP_OKAY;
        end
        // Ready drops while a beat is parked, which is the back-pressure
        awready_nxt = !aw_held_nxt;
        wready_nxt = !w_held_nxt;
        if (arvalid && arready_r)
        begin
            arready_nxt = 1'b0;
            rvalid_nxt = 1'b1;
            rresp_nxt = (rd_id == PNC_REG_NONE) ? RESP_SLVERR : RESP_OKAY;
            case (rd_id)
                PNC_REG_NOLOAD: rdata_nxt = {23'h00_0000, status_r};
                PNC_REG_COMPUTE: rdata_nxt = {16'h0000, cfg_r};
                PNC_REG_IRQ_ST: rdata_nxt = {29'h0000_0000, irq_st_r};
                PNC_REG_IRQ_MASK: rdata_nxt = {29'h0000_0000, mask_r};
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
        if (rvalid_r && rready)
        begin
            rvalid_nxt = 1'b0;
            arready_nxt = 1'b1;
        end
    end

    // Register state: flags, mode word, sticky events and mask
    always_comb
    begin
        status_nxt = noload_detect;
        ev_set[EV_TOTAL] = |(noload_detect.total_power_noload_flag & ~status_r.total_power_noload_flag);
        ev_set[EV_FUND] = |(noload_detect.fundamental_power_noload_flag & ~status_r.fundamental_power_noload_flag);
        ev_set[EV_APP] = |(noload_detect.apparent_power_noload_flag & ~status_r.apparent_power_noload_flag);
        cfg_nxt = cfg_r;
        mask_nxt = mask_r;
        irq_st_nxt = irq_st_r;
        if (wr_fire && wr_id == PNC_REG_COMPUTE)
        begin
            cfg_nxt = merge16(cfg_r, wdata_r[15:0], wstrb_r[1:0]);
        end
        if (wr_fire && wr_id == PNC_REG_IRQ_MASK && wstrb_r[0])
        begin
            mask_nxt = wdata_r[2:0];
        end
        // Write one to clear
        if (wr_fire && wr_id == PNC_REG_IRQ_ST && wstrb_r[0])
        begin
            irq_st_nxt = irq_st_r & ~wdata_r[2:0];
        end
        // A new event in the clearing cycle is kept: set wins
        irq_st_nxt = irq_st_nxt | ev_set;
        irq_nxt = |(irq_st_nxt & mask_nxt);
    end

    // Single register stage for both groups
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= RESP_OKAY;
            status_r <= NOLOAD_RESET;
            cfg_r <= COMPUTE_RESET;
            irq_st_r <= IRQ_STATUS_RESET;
            mask_r <= IRQ_MASK_RESET;
            irq_r <= 1'b0;
        end
        else
        begin
            aw_held_r <= aw_held_nxt;
            w_held_r <= w_held_nxt;
            awaddr_r <= awaddr_nxt;
            wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt;
            awready_r <= awready_nxt;
            wready_r <= wready_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            arready_r <= arready_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
            status_r <= status_nxt;
            cfg_r <= cfg_nxt;
            irq_st_r <= irq_st_nxt;
            mask_r <= mask_nxt;
            irq_r <= irq_nxt;
        end
    end

    // Outputs straight from flops; bit 15 of the mode word is carried
    // in the struct but nothing downstream may use it
    assign awready = awready_r;
    assign wready = wready_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign arready = arready_r;
    assign rvalid = rvalid_r;
    assign rdata = rdata_r;
    assign rresp = rresp_r;
    assign noload_flags = status_r;
    assign compute_mode = pnc_compute_t'(cfg_r);
    assign irq = irq_r;

    // Checks
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_total_rise;
        |(noload_detect.total_power_noload_flag & ~status_r.total_power_noload_flag);
    endsequence
    sequence s_fund_rise;
        |(noload_detect.fundamental_power_noload_flag & ~status_r.fundamental_power_noload_flag);
    endsequence
    sequence s_app_rise;
        |(noload_detect.apparent_power_noload_flag & ~status_r.apparent_power_noload_flag);
    endsequence
    sequence s_cfg_write;
        wr_fire && wr_id == PNC_REG_COMPUTE && wstrb_r == 4'hF;
    endsequence
    sequence s_both_taken;
        awvalid && awready_r && wvalid && wready_r && !bvalid_r;
    endsequence

    property p_total_flag;
        $past(aresetn) |-> noload_flags.total_power_noload_flag == $past(noload_detect.total_power_noload_flag);
    endproperty
    a_total_flag: assert property (p_total_flag) else $error("total flag does not follow detection");

    property p_total_event;
        s_total_rise |=> irq_st_r[EV_TOTAL] && noload_flags.total_power_noload_flag != 3'h0;
    endproperty
    a_total_event: assert property (p_total_event) else $error("total event not set with flag");

    property p_fund_flag;
        $past(aresetn) |-> noload_flags.fundamental_power_noload_flag
            == $past(noload_detect.fundamental_power_noload_flag);
    endproperty
    a_fund_flag: assert property (p_fund_flag) else $error("fundamental flag wrong");

    property p_fund_event;
        s_fund_rise |=> irq_st_r[EV_FUND] && noload_flags.fundamental_power_noload_flag != 3'h0;
    endproperty
    a_fund_event: assert property (p_fund_event) else $error("fundamental event not set");

    property p_app_clear;
        $past(aresetn) && $past(noload_detect.apparent_power_noload_flag) == 3'h0
            |-> noload_flags.apparent_power_noload_flag == 3'h0;
    endproperty
    a_app_clear: assert property (p_app_clear) else $error("apparent flag did not clear");

    property p_app_event;
        s_app_rise |=> irq_st_r[EV_APP] ##1 (irq_st_r[EV_APP] || $past(wr_fire && wr_id == PNC_REG_IRQ_ST));
    endproperty
    a_app_event: assert property (p_app_event) else $error("apparent event not sticky");

    property p_reset_values;
        $past(aresetn) == 1'b0 |-> noload_flags == NOLOAD_RESET && cfg_r == COMPUTE_RESET && !irq;
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("wrong reset value");

    property p_cfg_write;
        s_cfg_write |=> compute_mode == pnc_compute_t'($past(wdata_r[15:0]));
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("mode word write lost");

    property p_write_answer;
        s_both_taken |-> ##[1:2] bvalid_r;
    endproperty
    a_write_answer: assert property (p_write_answer) else $error("write response late");

    property p_read_answer;
        arvalid && arready_r && rd_id == PNC_REG_NOLOAD |=> rvalid_r && !arready_r && rdata_r[15:9] == 7'h00;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("no-load read answer wrong");

    // mode word held; only a bus write may move it
    property p_mode_hold;
        !(wr_fire && wr_id == PNC_REG_COMPUTE) |=> $stable(cfg_r);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode word changed without a write");

    property p_nominal_map;
        compute_mode.nominal_volt_use == cfg_r[13:11];
    endproperty
    a_nominal_map: assert property (p_nominal_map) else $error("enable bits misplaced");

    // Interrupt line follows the unmasked sticky bits
    property p_irq_level;
        irq == |(irq_st_r & mask_r);
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

endmodule

// file: pnc_pkg.sv
package pnc_pkg;

    // Bus address width: word index plus two byte bits
    localparam int ADDR_W = 18;

    // Word indices; the byte address is four times the index
    localparam logic [15:0] IDX_NOLOAD = 16'hE608;
    localparam logic [15:0] IDX_COMPUTE = 16'hE60E;
    localparam logic [15:0] IDX_IRQ_STATUS = 16'hE620;
    localparam logic [15:0] IDX_IRQ_MASK = 16'hE621;

    // Reset values
    localparam logic [15:0] COMPUTE_RESET = 16'h01FF;
    localparam logic [8:0] NOLOAD_RESET = 9'h000;
    localparam logic [2:0] IRQ_STATUS_RESET = 3'h0;
    localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

    // Event bit positions in the main interrupt status register
    localparam int EV_TOTAL = 0;
    localparam int EV_FUND = 1;
    localparam int EV_APP = 2;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        PNC_ANG_VOLT_CURR = 2'b00,
        PNC_ANG_VOLT_VOLT = 2'b01,
        PNC_ANG_CURR_CURR = 2'b10,
        PNC_ANG_NONE = 2'b11
    } pnc_angle_t;

    // Computation-mode layout, bit 15 down to bit 0
    typedef struct packed {
        logic spare;
        logic line_freq_select;
        logic [2:0] nominal_volt_use;
        pnc_angle_t angle_measure_select;
        logic [2:0] pulse3_phase_select;
        logic [2:0] pulse2_phase_select;
        logic [2:0] pulse1_phase_select;
    } pnc_compute_t;

    // No-load flags, bit 8 down to bit 0; index 0 is phase A
    typedef struct packed {
        logic [2:0] apparent_power_noload_flag;
        logic [2:0] fundamental_power_noload_flag;
        logic [2:0] total_power_noload_flag;
    } pnc_noload_t;

    typedef enum logic [2:0] {
        PNC_REG_NONE = 3'b000,
        PNC_REG_NOLOAD = 3'b001,
        PNC_REG_COMPUTE = 3'b010,
        PNC_REG_IRQ_ST = 3'b011,
        PNC_REG_IRQ_MASK = 3'b100
    } pnc_reg_t;

endpackage
